// *** logic/rcdfr_pkg.sv ***
/*
 * Package for the reset cause and debug force reset block.
 * Assumes the surrounding chip decodes the register addresses into selects.
 */
package rcdfr_pkg;
    // ------------------------------------------------------------
    // Reset cause flag positions
    // ------------------------------------------------------------
    localparam int FLAG_POWER_ON   = 7;
    localparam int FLAG_EXT_PIN    = 6;
    localparam int FLAG_WATCHDOG   = 5;
    localparam int FLAG_ILLEGAL_OP = 4;
    localparam int FLAG_BAD_ADDR   = 3;
    localparam int FLAG_CLK_LOSS   = 2;
    localparam int FLAG_UNDERVOLT  = 1;
    localparam int FLAG_UNUSED     = 0;

    // ------------------------------------------------------------
    // Values and layout
    // ------------------------------------------------------------
    localparam logic [7:0] SERVICE_KEY1   = 8'h55;
    localparam logic [7:0] SERVICE_KEY2   = 8'haa;
    localparam logic [7:0] FLAGS_CLEAR    = 8'h00;
    localparam logic [7:0] DEBUG_READ_VAL = 8'h00;
    localparam int         FORCE_BIT      = 0;
    localparam int         WDOG_CNT_W     = 18;
    localparam logic [WDOG_CNT_W-1:0] WDOG_TIMEOUT_DEF = 18'h3ffff;
    // Window opens after three quarters of the period
    localparam int         WINDOW_NUM     = 3;
    localparam int         WINDOW_SHIFT   = 2;
    localparam logic [3:0] RESET_HOLD     = 4'h8;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic power_on;
        logic ext_pin;
        logic clk_loss;
        logic undervolt;
        logic illegal_op;
        logic bad_addr;
        logic stop_exec;
        logic halt_to_debug_instruction;
    } rcdfr_sources_t;

    typedef struct packed {
        logic watchdog_active;
        logic window_mode;
        logic stop_allow;
        logic background_mode_allow;
        logic undervoltage_reset_allow;
    } rcdfr_config_t;

    typedef enum logic [1:0] {
        WD_IDLE,
        WD_GOT_KEY1
    } rcdfr_wd_state_t;
endpackage

// *** logic/rcdfr_top.sv ***
/*
 * Reset cause flags, watchdog service and debug force reset.
 * Assumes an external reset controller acts on chip_reset_q without
 * pulsing rst_n, since rst_n would wipe the captured cause; rst_n stands
 * for the first power-up only. Sources are asynchronous levels held for
 * at least three clocks; cfg already lives on clk_sys.
 * Limitation: a watchdog trip stays raised until rst_n, so the request
 * repeats after every hold period until the controller pulls rst_n.
 */
// Functional notes
// R1 - Cause flags are read-only to software
// R2 - Power-on sets bits seven and one
// R3 - Reset pin sets bit six
// R4 - Watchdog timeout sets bit five, if enabled
// R5 - Illegal opcode or disallowed stop sets bit four
// R6 - Halt-to-debug illegal when background mode disallowed
// R7 - Bad address access sets bit three
// R8 - Clock loss sets bit two
// R9 - Allowed undervoltage trip sets bit one
// R10 - Other resets latch active sources only
// R11 - Debug forced reset leaves flags clear
// R12 - Non-key write trips watchdog when enabled
// R13 - Key pair clears watchdog, flags untouched
// R14 - Early write in window mode resets
// R15 - Only debug link writes force bit
// R16 - CPU writes to force register ignored
// R17 - Force register always reads zero
// R18 - Debug write of bit zero resets
// R19 - Cause bit zero reads zero
`timescale 1ns/1ps
module rcdfr_top
    import rcdfr_pkg::*;
#(
    parameter logic [WDOG_CNT_W-1:0] WDOG_TIMEOUT = WDOG_TIMEOUT_DEF
) (
    input  wire logic           clk_sys,         // Bus clock, 25 MHz
    input  wire logic           rst_n,           // Async chip reset, active low
    input  wire rcdfr_sources_t src_raw,         // Reset sources, asynchronous
    input  wire rcdfr_config_t  cfg,             // Configuration, same clock
    input  wire logic           cause_sel,       // Cause register selected
    input  wire logic           debug_sel,       // Force register selected
    input  wire logic           bus_wr,          // Write strobe
    input  wire logic           bus_rd,          // Read strobe
    input  wire logic           bus_from_debug,  // Access from debug link
    input  wire logic [7:0]     bus_wdata,       // Write data
    output logic [7:0]          bus_rdata_q,     // Read data
    output logic [7:0]          cause_flags_q,   // Cause register view
    output logic                chip_reset_q     // Reset request to controller
);
    // ------------------------------------------------------------
    // Source synchronisers
    // ------------------------------------------------------------
    rcdfr_sources_t src_meta_q;
    rcdfr_sources_t src_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_meta_q <= '0;
            src_q      <= '0;
        end else begin
            src_meta_q <= src_raw;
            src_q      <= src_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    // CPU writes to the force register have no strobe of their own, so
    // they cannot reach anything.
    logic cpu_cause_wr;
    logic link_debug_wr;
    logic cause_rd;
    logic debug_rd;

    assign cpu_cause_wr  = cause_sel && bus_wr && !bus_from_debug;
    assign link_debug_wr = debug_sel && bus_wr && bus_from_debug;     // [R15] [R16]
    assign cause_rd      = cause_sel && bus_rd;
    assign debug_rd      = debug_sel && bus_rd;

    // ------------------------------------------------------------
    // Reset source qualification
    // ------------------------------------------------------------
    logic       illegal_op;
    logic       undervolt_trip;
    logic       wdog_trip;
    logic       debug_force;
    logic       any_cause;
    logic       entry;
    logic [7:0] live;

    assign illegal_op = src_q.illegal_op
                     || (src_q.stop_exec && !cfg.stop_allow)                    // [R5]
                     || (src_q.halt_to_debug_instruction && !cfg.background_mode_allow); // [R6]
    assign undervolt_trip = src_q.undervolt && cfg.undervoltage_reset_allow;   // [R9]
    // Only the debug link can reach the force bit
    assign debug_force = link_debug_wr && bus_wdata[FORCE_BIT];               // [R15] [R16] [R18]

    rcdfr_watchdog #(
        .TIMEOUT (WDOG_TIMEOUT)
    ) u_wdog (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .active      (cfg.watchdog_active),
        .window_mode (cfg.window_mode),
        .wr_stb      (cpu_cause_wr),
        .wr_data     (bus_wdata),
        .trip_q      (wdog_trip)
    );

    // ------------------------------------------------------------
    // Qualified sources by flag position
    // ------------------------------------------------------------
    always_comb begin
        live                  = FLAGS_CLEAR;
        live[FLAG_POWER_ON]   = src_q.power_on;       // [R2]
        live[FLAG_EXT_PIN]    = src_q.ext_pin;        // [R3]
        live[FLAG_WATCHDOG]   = wdog_trip;            // [R4]
        live[FLAG_ILLEGAL_OP] = illegal_op;           // [R5] [R6]
        live[FLAG_BAD_ADDR]   = src_q.bad_addr;       // [R7]
        live[FLAG_CLK_LOSS]   = src_q.clk_loss;       // [R8]
        live[FLAG_UNDERVOLT]  = undervolt_trip;       // [R9]
    end

    // Power-on is a cause like the others, so its flags are captured too
    assign any_cause = |live;
    // A request already running swallows new causes until it ends
    assign entry     = !chip_reset_q && (debug_force || any_cause);

    // ------------------------------------------------------------
    // Pending cause, captured at reset entry
    // ------------------------------------------------------------
    // Flags survive only in this hold register; the controller is expected
    // not to reset it on the reset it requested, so we rebuild at power-on.
    logic [7:0] pend_q;
    logic [7:0] pend_d;
    logic       forced_q;
    logic [3:0] hold_q;

    always_comb begin
        pend_d = live;                                // [R10]
        pend_d[FLAG_POWER_ON]  = 1'b0;                // [R10]
        pend_d[FLAG_UNDERVOLT] = 1'b0;                // [R10]
        if (live[FLAG_POWER_ON]) begin
            pend_d = FLAGS_CLEAR;
            pend_d[FLAG_POWER_ON]  = 1'b1;            // [R2]
            pend_d[FLAG_UNDERVOLT] = 1'b1;            // [R2]
        end else if (undervolt_trip) begin
            pend_d = FLAGS_CLEAR;
            pend_d[FLAG_UNDERVOLT] = 1'b1;            // [R9]
        end
        pend_d[FLAG_UNUSED] = 1'b0;                   // [R19]
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            forced_q <= 1'b0;
        end else if (entry) begin
            forced_q <= debug_force;                  // [R11]
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= FLAGS_CLEAR;
        end else if (entry) begin
            if (debug_force) begin
                pend_q <= FLAGS_CLEAR;                // [R11]
            end else begin
                pend_q <= pend_d;
            end
        end
    end

    // Hold the reset request long enough for the controller to see it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chip_reset_q <= 1'b0;
            hold_q       <= '0;
        end else if (!chip_reset_q) begin
            if (debug_force || any_cause) begin
                chip_reset_q <= 1'b1;                 // [R18]
                hold_q       <= RESET_HOLD;
            end
        end else if (hold_q != '0) begin
            hold_q <= hold_q - 1'b1;
        end else begin
            chip_reset_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Cause register
    // ------------------------------------------------------------
    // Power-on dominates; otherwise the pending view is published.
    logic [7:0] cause_d;

    always_comb begin
        cause_d = pend_q;
        if (src_q.power_on) begin
            cause_d = FLAGS_CLEAR;
            cause_d[FLAG_POWER_ON]  = 1'b1;           // [R2]
            cause_d[FLAG_UNDERVOLT] = 1'b1;           // [R2]
        end else if (forced_q) begin
            cause_d = FLAGS_CLEAR;                    // [R11]
        end
        cause_d[FLAG_UNUSED] = 1'b0;                  // [R19]
    end

    // No bus write path reaches the flags
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cause_flags_q <= FLAGS_CLEAR;
        end else begin
            cause_flags_q <= cause_d;                 // [R1]
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata_q <= FLAGS_CLEAR;
        end else if (cause_rd) begin
            bus_rdata_q <= cause_flags_q;             // [R1]
        end else if (debug_rd) begin
            bus_rdata_q <= DEBUG_READ_VAL;            // [R17]
        end else begin
            bus_rdata_q <= FLAGS_CLEAR;
        end
    end
endmodule

// *** logic/rcdfr_watchdog.sv ***
/*
 * Watchdog counter with key-sequence service and window check.
 * Assumes bus writes to the reset cause address arrive as one-cycle strobes.
 */
`timescale 1ns/1ps
module rcdfr_watchdog
    import rcdfr_pkg::*;
#(
    parameter logic [WDOG_CNT_W-1:0] TIMEOUT = WDOG_TIMEOUT_DEF
) (
    input  wire logic       clk_sys,      // Bus clock
    input  wire logic       rst_n,        // Async reset, active low
    input  wire logic       active,       // Watchdog running
    input  wire logic       window_mode,  // Windowed service mode
    input  wire logic       wr_stb,       // Write to cause address
    input  wire logic [7:0] wr_data,      // Written byte
    output logic            trip_q        // Watchdog reset request
);
    // ------------------------------------------------------------
    // Key sequence and counter
    // ------------------------------------------------------------
    localparam logic [WDOG_CNT_W-1:0] WINDOW_OPEN =
        WDOG_CNT_W'((TIMEOUT * WINDOW_NUM) >> WINDOW_SHIFT);

    rcdfr_wd_state_t        state_q;
    logic [WDOG_CNT_W-1:0]  count_q;
    logic                   early;
    logic                   bad_byte;
    logic                   serviced;

    assign early    = window_mode && (count_q < WINDOW_OPEN);
    assign bad_byte = (wr_data != SERVICE_KEY1) && (wr_data != SERVICE_KEY2);
    assign serviced = wr_stb && (state_q == WD_GOT_KEY1) && (wr_data == SERVICE_KEY2);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= WD_IDLE;
        end else if (wr_stb) begin
            case (state_q)
                WD_IDLE:     state_q <= (wr_data == SERVICE_KEY1) ? WD_GOT_KEY1 : WD_IDLE;
                WD_GOT_KEY1: state_q <= (wr_data == SERVICE_KEY1) ? WD_GOT_KEY1 : WD_IDLE;
                default:     state_q <= WD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (!active || serviced) begin
            count_q <= '0; // [R13]
        end else if (count_q != TIMEOUT) begin
            count_q <= count_q + 1'b1;
        end
    end

    // Trip is sticky until the chip reset clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trip_q <= 1'b0;
        end else if (active) begin
            if (count_q == TIMEOUT) begin
                trip_q <= 1'b1; // [R4]
            end
            if (wr_stb && bad_byte) begin
                trip_q <= 1'b1; // [R12]
            end
            if (wr_stb && early) begin
                trip_q <= 1'b1; // [R14]
            end
        end
    end
endmodule

// *** tb/rcdfr_checker.sv ***
/* Port assertions for the reset cause block.
   Assumes binding into rcdfr_top; one clock domain. */
`timescale 1ns/1ps
module rcdfr_checker
    import rcdfr_pkg::*;
#(
    parameter logic [WDOG_CNT_W-1:0] WDOG_TIMEOUT = WDOG_TIMEOUT_DEF
) (
    input wire logic           clk_sys,        // Bus clock
    input wire logic           rst_n,          // Reset, active low
    input wire rcdfr_sources_t src_raw,        // Sources
    input wire rcdfr_config_t  cfg,            // Config
    input wire logic           cause_sel,      // Cause select
    input wire logic           debug_sel,      // Force select
    input wire logic           bus_wr,         // Write strobe
    input wire logic           bus_rd,         // Read strobe
    input wire logic           bus_from_debug, // Debug access
    input wire logic [7:0]     bus_wdata,      // Write data
    input wire logic [7:0]     bus_rdata_q,    // Read data
    input wire logic [7:0]     cause_flags_q,  // Flags
    input wire logic           chip_reset_q    // Reset request
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic cpu_wr;
    logic dbg_force;
    assign cpu_wr = cause_sel && bus_wr && !bus_from_debug && !chip_reset_q;
    assign dbg_force = debug_sel && bus_wr && bus_from_debug && bus_wdata[FORCE_BIT]
                       && !chip_reset_q;

    a_force_reads_zero:
        assert property (debug_sel && bus_rd |=> bus_rdata_q == DEBUG_READ_VAL)
        else $error("force register read not zero");
    a_cause_read_back:
        assert property (cause_sel && bus_rd |=> bus_rdata_q == $past(cause_flags_q))
        else $error("cause read data wrong");
    a_bit0_zero:
        assert property (cause_flags_q[FLAG_UNUSED] == 1'b0) else $error("bit 0 set");
    a_flags_static:
        assert property ((!chip_reset_q)[*4] |-> $stable(cause_flags_q))
        else $error("flags changed outside reset");
    a_force_clears:
        assert property (dbg_force |=> chip_reset_q ##1 cause_flags_q == FLAGS_CLEAR)
        else $error("debug force reset wrong");
    a_cpu_force_ignored:
        assert property ((src_raw == '0)[*3] ##0 (debug_sel && bus_wr && !bus_from_debug
            && !chip_reset_q && !cfg.watchdog_active) |=> !chip_reset_q)
        else $error("cpu force write acted");
    a_hold_nine:
        assert property ($rose(chip_reset_q) |-> chip_reset_q[*8] ##1 chip_reset_q
            ##1 !chip_reset_q) else $error("reset request length wrong");
    a_bad_key_trips:
        assert property (cfg.watchdog_active && cpu_wr && bus_wdata != SERVICE_KEY1
            && bus_wdata != SERVICE_KEY2 |-> ##[1:3] chip_reset_q)
        else $error("bad key did not trip");
    a_pin_resets:
        assert property ($rose(src_raw.ext_pin) && !chip_reset_q |-> ##[1:4] chip_reset_q)
        else $error("pin source ignored");
endmodule

bind rcdfr_top rcdfr_checker #(.WDOG_TIMEOUT(WDOG_TIMEOUT)) u_chk (.clk_sys, .rst_n,
    .src_raw, .cfg, .cause_sel, .debug_sel, .bus_wr, .bus_rd, .bus_from_debug,
    .bus_wdata, .bus_rdata_q, .cause_flags_q, .chip_reset_q);

// *** tb/rcdfr_host_model.sv ***
/* CPU and debug host driving the register selects.
   Assumes one-cycle strobes launched at the falling edge. */
`timescale 1ns/1ps
module rcdfr_host_model
    import rcdfr_pkg::*;
(
    input  wire logic       clk_sys,        // Bus clock
    input  wire logic [7:0] bus_rdata_q,    // Read data
    output logic            cause_sel,      // Cause select
    output logic            debug_sel,      // Force select
    output logic            bus_wr,         // Write strobe
    output logic            bus_rd,         // Read strobe
    output logic            bus_from_debug, // Debug access
    output logic [7:0]      bus_wdata       // Write data
);
    initial begin
        {cause_sel, debug_sel, bus_wr, bus_rd, bus_from_debug} = '0;
        bus_wdata = 8'h00;
    end
    // Mode bits: force register, debug link, read
    task automatic xfer(input logic [2:0] m, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_sys);
        {cause_sel, debug_sel, bus_from_debug, bus_rd, bus_wr, bus_wdata} =
            {!m[2], m[2], m[1], m[0], !m[0], d};
        @(negedge clk_sys);
        q = bus_rdata_q;
        {cause_sel, debug_sel, bus_wr, bus_rd, bus_from_debug} = '0;
        // Released data never keeps the old value
        bus_wdata = ~d;
    endtask
    task automatic svc();
        logic [7:0] q;
        xfer(3'b000, SERVICE_KEY1, q);
        xfer(3'b000, SERVICE_KEY2, q);
    endtask
endmodule

// *** tb/rcdfr_test.sv ***
/* Self-checking bench for rcdfr_top.
   Assumes the host model owns the register bus. */
`timescale 1ns/1ps
module rcdfr_test;
    import rcdfr_pkg::*;
    typedef struct {rcdfr_sources_t s; rcdfr_config_t c; logic [7:0] f;} rcdfr_row_t;
    logic           clk_sys = 1'b0;
    logic           rst_n = 1'b0;
    rcdfr_sources_t src_raw = '0;
    rcdfr_config_t  cfg = '0;
    logic           cause_sel, debug_sel, bus_wr, bus_rd, bus_from_debug, chip_reset_q;
    logic [7:0]     bus_wdata, bus_rdata_q, cause_flags_q, rd_q;
    int             err_total = 0;
    int             check_count = 0;
    rcdfr_row_t rows [9] = '{'{8'h40, 5'h00, 8'h40}, '{8'h20, 5'h00, 8'h04},
        '{8'h10, 5'h01, 8'h02}, '{8'h08, 5'h00, 8'h10}, '{8'h04, 5'h00, 8'h08},
        '{8'h02, 5'h00, 8'h10}, '{8'h01, 5'h00, 8'h10}, '{8'h80, 5'h00, 8'h82},
        '{8'h48, 5'h00, 8'h50}};
    rcdfr_row_t calm [3] = '{'{8'h10, 5'h00, 8'h00}, '{8'h02, 5'h04, 8'h00},
        '{8'h01, 5'h02, 8'h00}};
    always #20 clk_sys = ~clk_sys;
    rcdfr_top #(.WDOG_TIMEOUT(18'd64)) i_dut (.clk_sys, .rst_n, .src_raw, .cfg,
        .cause_sel, .debug_sel, .bus_wr, .bus_rd, .bus_from_debug, .bus_wdata,
        .bus_rdata_q, .cause_flags_q, .chip_reset_q);
    rcdfr_host_model i_host (.clk_sys, .bus_rdata_q, .cause_sel, .debug_sel, .bus_wr,
        .bus_rd, .bus_from_debug, .bus_wdata);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic restart(input rcdfr_config_t c, input int n);
        rst_n = 1'b0;
        cfg = c;
        src_raw = '0;
        repeat (n) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic wait_rst(input logic lvl, input int lim);
        int n;
        n = 0;
        while (chip_reset_q !== lvl && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h00, chip_reset_q}, {7'h00, lvl});
        if (chip_reset_q !== lvl) begin
            finish_test();
        end
    endtask
    task automatic expect_reset(input rcdfr_sources_t s, input logic [7:0] f, input int lim);
        src_raw = s;
        wait_rst(1'b1, lim);
        src_raw = '0;
        wait_rst(1'b0, 20);
        chk(cause_flags_q, f);
        i_host.xfer(3'b001, 8'h00, rd_q);
        chk(rd_q, f);
    endtask
    task automatic quiet();
        repeat (10) begin
            @(negedge clk_sys);
            chk({7'h00, chip_reset_q}, 8'h00);
        end
    endtask
    initial begin
        restart('0, 6);
        chk(cause_flags_q, 8'h00);
        // Each source alone, then two at once
        foreach (rows[i]) begin
            restart(rows[i].c, 2);
            expect_reset(rows[i].s, rows[i].f, 8);
            i_host.xfer(3'b000, 8'h00, rd_q);
            chk(cause_flags_q, rows[i].f);
        end
        // Gated sources stay harmless
        foreach (calm[i]) begin
            restart(calm[i].c, 2);
            src_raw = calm[i].s;
            quiet();
        end
        restart('0, 2);
        i_host.xfer(3'b000, 8'h12, rd_q);
        i_host.xfer(3'b100, 8'h01, rd_q);
        i_host.xfer(3'b101, 8'h00, rd_q);
        chk(rd_q, 8'h00);
        quiet();
        // Service spans more than two timeouts
        restart(5'h10, 2);
        repeat (6) begin
            repeat (20) @(negedge clk_sys);
            i_host.svc();
        end
        chk(cause_flags_q, 8'h00);
        i_host.xfer(3'b000, 8'h12, rd_q);
        expect_reset('0, 8'h20, 8);
        restart(5'h10, 2);
        expect_reset('0, 8'h20, 100);
        // Window: late service is fine, a second one ten quiet clocks later is early
        restart(5'h18, 2);
        repeat (50) @(negedge clk_sys);
        i_host.svc();
        quiet();
        i_host.svc();
        expect_reset('0, 8'h20, 8);
        restart('0, 2);
        // Force after a pin reset must wipe the pin flag
        expect_reset(8'h40, 8'h40, 8);
        i_host.xfer(3'b110, 8'h01, rd_q);
        expect_reset('0, 8'h00, 8);
        finish_test();
    end
endmodule
